// file: rtl/gim_pkg.sv
package gim_pkg;

	// Register word indices on the Avalon slave (word addressing).
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_RXD = 2'h2;
	localparam logic [1:0] REG_TXD = 2'h3;

	// Control register fields and their reset values.
	localparam int CTRL_ADDR_LSB = 0;
	localparam int CTRL_CRONLY_BIT = 5;
	localparam int CTRL_STB_LSB = 8;
	localparam logic [4:0] ADDR_RST = 5'h05;
	localparam logic CRONLY_RST = 1'b0;

	// Status register bits that software writes.
	localparam int ST_RSV = 4;
	localparam int ST_MSGDONE = 7;
	localparam int ST_DCL = 9;
	localparam int ST_TRG = 10;

	// Data word fields.
	localparam int DW_LAST_BIT = 8;
	localparam int DW_STB_BIT = 9;
	localparam int STB_RSV_BIT = 6;

	// Terminator characters.
	localparam logic [7:0] CHR_CR = 8'h0D;
	localparam logic [7:0] CHR_LF = 8'h0A;

	// Bus command groups and codes, seven bits.
	localparam logic [1:0] GRP_LAG = 2'h1;
	localparam logic [1:0] GRP_TAG = 2'h2;
	localparam logic [1:0] GRP_SCG = 2'h3;
	localparam logic [4:0] ADDR_NONE = 5'h1F;
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_PPC = 7'h05;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_PPU = 7'h15;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;

	// Data settle time before the source asserts data valid.
	localparam int CLK_NS = 25;
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	// Bus lines after synchronising, a one meaning the line is true.
	typedef struct packed {
		logic atn;
		logic eoi;
		logic ifc;
		logic ren;
		logic dav;
		logic nrfd;
		logic ndac;
		logic [7:0] dio;
	} gim_bus_t;

endpackage

// file: rtl/gim_hs_if.sv
interface gim_hs_if;
	logic acc_en;
	logic can_take;
	logic rx_stb;
	logic rx_atn;
	logic rx_eoi;
	logic [7:0] rx_byte;
	logic src_en;
	logic tx_req;
	logic tx_done;

	// The handshake engine and the controller that steers it.
	modport eng (input acc_en, can_take, src_en, tx_req,
		output rx_stb, rx_atn, rx_eoi, rx_byte, tx_done);
	modport ctl (output acc_en, can_take, src_en, tx_req,
		input rx_stb, rx_atn, rx_eoi, rx_byte, tx_done);
endinterface

// file: rtl/gim_sync.sv
module gim_sync #(
	parameter int W = 15
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Raw and synchronised lines.
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gim_sync_st_t;

	gim_sync_st_t st_q;
	gim_sync_st_t st_d;

	// Only the second stage is seen outside, so metastability stays in the first.
	always_comb begin
		st_d.s1 = i_d;
		st_d.s2 = st_q.s1;
	end

	// The lines reset to false.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_q = st_q.s2;

endmodule // gim_sync

// file: rtl/gim_hs.sv
module gim_hs (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Synchronised bus lines.
	input wire gim_pkg::gim_bus_t i_bus,
	// Controller side.
	gim_hs_if.eng hsp,
	// Handshake pin drives.
	output logic o_dav_n,
	output logic o_dav_oe_n,
	output logic o_nrfd_oe_n,
	output logic o_ndac_oe_n
);

	typedef enum logic [1:0] {A_OFF, A_HOLD, A_RDY, A_ACC} gim_acc_st_t;
	typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_WAIT, S_DAV} gim_src_st_t;
	typedef struct packed {
		gim_acc_st_t a;
		gim_src_st_t s;
		logic [2:0] cnt;
		logic nrfd_oe_n;
		logic ndac_oe_n;
		logic dav_n;
		logic dav_oe_n;
		logic rx_stb;
		logic rx_atn;
		logic rx_eoi;
		logic [7:0] rx_byte;
		logic tx_done;
	} gim_hs_st_t;

	gim_hs_st_t st_q;
	gim_hs_st_t st_d;

	// Acceptor and source handshakes run side by side; only one is ever enabled.
	always_comb begin
		st_d = st_q;
		st_d.rx_stb = 1'b0;
		st_d.tx_done = 1'b0;
		unique case (st_q.a)
			A_OFF: begin
				if (hsp.acc_en) begin
					st_d.a = A_HOLD;
				end
			end
			A_HOLD: begin
				if (!hsp.acc_en) begin
					st_d.a = A_OFF;
				end else if (hsp.can_take && !i_bus.dav) begin
					st_d.a = A_RDY;
				end
			end
			A_RDY: begin
				if (!hsp.acc_en) begin
					st_d.a = A_OFF;
				end else if (i_bus.dav) begin
					st_d.a = A_ACC;
					st_d.rx_stb = 1'b1;
					st_d.rx_atn = i_bus.atn;
					st_d.rx_eoi = i_bus.eoi;
					st_d.rx_byte = i_bus.dio;
				end
			end
			A_ACC: begin
				if (!i_bus.dav) begin
					st_d.a = hsp.acc_en ? A_HOLD : A_OFF;
				end
			end
		endcase
		// While the acceptor is on, not ready is held except while waiting for a byte; not accepted until one is taken.
		st_d.nrfd_oe_n = !(st_d.a == A_HOLD || st_d.a == A_ACC);
		st_d.ndac_oe_n = !(st_d.a == A_HOLD || st_d.a == A_RDY);
		unique case (st_q.s)
			S_IDLE: begin
				if (hsp.src_en && hsp.tx_req && !st_q.tx_done) begin
					st_d.s = S_SETTLE;
					st_d.cnt = 3'(gim_pkg::SETTLE_CYC - 1);
				end
			end
			S_SETTLE: begin
				if (st_q.cnt == 3'h0) begin
					st_d.s = S_WAIT;
				end else begin
					st_d.cnt = st_q.cnt - 3'h1;
				end
			end
			S_WAIT: begin
				if (i_bus.ndac && !i_bus.nrfd) begin
					st_d.s = S_DAV;
				end
			end
			S_DAV: begin
				if (!i_bus.ndac) begin
					st_d.s = S_IDLE;
					st_d.tx_done = 1'b1;
				end
			end
		endcase
		if (!hsp.src_en) begin
			st_d.s = S_IDLE;
		end
		st_d.dav_n = !(st_d.s == S_DAV);
		st_d.dav_oe_n = !hsp.src_en;
	end

	// All pins released after reset.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_q <= '{a: A_OFF, s: S_IDLE, cnt: 3'h0, nrfd_oe_n: 1'b1, ndac_oe_n: 1'b1,
				dav_n: 1'b1, dav_oe_n: 1'b1, rx_stb: 1'b0, rx_atn: 1'b0, rx_eoi: 1'b0,
				rx_byte: 8'h00, tx_done: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign hsp.rx_stb = st_q.rx_stb;
	assign hsp.rx_atn = st_q.rx_atn;
	assign hsp.rx_eoi = st_q.rx_eoi;
	assign hsp.rx_byte = st_q.rx_byte;
	assign hsp.tx_done = st_q.tx_done;
	assign o_dav_n = st_q.dav_n;
	assign o_dav_oe_n = st_q.dav_oe_n;
	assign o_nrfd_oe_n = st_q.nrfd_oe_n;
	assign o_ndac_oe_n = st_q.ndac_oe_n;

	a_dav_ready: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(st_q.dav_n) |-> $past(i_bus.ndac && !i_bus.nrfd))
		else $error("Data valid asserted before listeners were ready.");

endmodule // gim_hs

// file: rtl/gim_top.sv
// Contract
// - Attention true: bytes are commands for all.
// - Attention false: data only when addressed listener.
// - Talker asserts end-or-identify on final byte.
// - Attention with end-or-identify means parallel poll.
// - Interface clear: unaddress, service request idle.
// - Remote and addressed: bus rules, panel ignored. The code ignores the panel local key only under lockout.
// - Remote enable false returns to local.
// - Service request: assert line, supply status byte.
// - Status byte on serial poll or request.
// - Listen only when addressed to listen.
// - Full handshakes, poll, clear and trigger.
// - Data drivers are three-state.
// - Bus address resets to five, writable.
// - Terminator CR LF, or CR alone.
// - Remote device both listens and talks.
// - Data strings forwarded to internal decoder.
// - All bus lines are active low.
// - Data valid only after listeners ready.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module gim_top (
	// Clock and reset.
	input wire logic I_CLK,
	input wire logic I_RESET,
	// Avalon-MM slave.
	input wire logic [1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// Bus lines as read from the wire, active low.
	input wire logic I_ATN_N,
	input wire logic I_EOI_N,
	input wire logic I_IFC_N,
	input wire logic I_REN_N,
	input wire logic I_DAV_N,
	input wire logic I_NRFD_N,
	input wire logic I_NDAC_N,
	input wire logic [7:0] I_DIO_N,
	// Bus drives, enable low while driving.
	output logic [7:0] O_DIO_N,
	output logic [7:0] O_DIO_OE_N,
	output logic O_DAV_N,
	output logic O_DAV_OE_N,
	output logic O_EOI_N,
	output logic O_EOI_OE_N,
	output logic O_NRFD_OE_N,
	output logic O_NDAC_OE_N,
	output logic O_SRQ_OE_N,
	// Instrument side.
	input wire logic I_PANEL_LOCAL,
	output logic O_REMOTE,
	output logic O_DEV_CLEAR,
	output logic O_TRIGGER
);

	typedef struct packed {
		logic [4:0] addr;
		logic cr_only;
		logic [7:0] stb;
		logic rsv;
		logic remote;
		logic lockout;
		logic listen;
		logic talk;
		logic spoll;
		logic pp_cfg;
		logic pp_en;
		logic pp_sense;
		logic [2:0] pp_line;
		logic [7:0] rx_byte;
		logic rx_eoi;
		logic rx_full;
		logic cr_seen;
		logic msg_done;
		logic dcl;
		logic trg;
		logic dcl_p;
		logic trg_p;
		logic [7:0] tx_byte;
		logic tx_last;
		logic tx_req;
		logic tx_stb;
		logic [7:0] dio_n;
		logic [7:0] dio_oe_n;
		logic eoi_n;
		logic eoi_oe_n;
		logic srq_oe_n;
		logic wreq;
		logic [31:0] rdata;
	} gim_top_st_t;

	localparam gim_top_st_t TOP_RST = '{addr: gim_pkg::ADDR_RST, cr_only: gim_pkg::CRONLY_RST,
		dio_n: 8'hFF, dio_oe_n: 8'hFF, eoi_n: 1'b1, eoi_oe_n: 1'b1, srq_oe_n: 1'b1, wreq: 1'b1,
		default: '0};

	gim_top_st_t st_q;
	gim_top_st_t st_d;
	logic [14:0] bus_raw;
	logic [14:0] bus_sync;
	gim_pkg::gim_bus_t b;
	logic [6:0] cmd;
	logic req;
	logic acc;
	logic ppoll;
	logic src_act;
	logic [7:0] src_data;
	logic [31:0] wd;

	gim_hs_if hs();

	// Status byte with the service request bit in its fixed place.
	function automatic logic [7:0] stb_byte(input gim_top_st_t s);
		logic [7:0] v;
		v = s.stb;
		v[gim_pkg::STB_RSV_BIT] = s.rsv;
		return v;
	endfunction

	// Read word for each register; write-only data reads as zero.
	function automatic logic [31:0] rd_word(input gim_top_st_t s, input logic [1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			gim_pkg::REG_CTRL: v = {16'h0000, s.stb, 2'h0, s.cr_only, s.addr};
			gim_pkg::REG_STAT: v = {20'h00000, s.pp_en, s.trg, s.dcl, s.lockout, s.msg_done,
				s.tx_req, s.rx_full, s.rsv, s.spoll, s.talk, s.listen, s.remote};
			gim_pkg::REG_RXD: v = {22'h000000, s.rx_full, s.rx_eoi, s.rx_byte};
			gim_pkg::REG_TXD: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus input conditioning.

	// Lines are inverted to true-high ahead of the synchroniser, so high means true.
	assign bus_raw = {~I_ATN_N, ~I_EOI_N, ~I_IFC_N, ~I_REN_N, ~I_DAV_N, ~I_NRFD_N, ~I_NDAC_N, ~I_DIO_N};

	gim_sync #(.W(15)) u_sync (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.i_d(bus_raw),
		.o_q(bus_sync)
	);

	assign b = gim_pkg::gim_bus_t'(bus_sync);

	////////////////////////////////////////////////////////////////////////////
	// Handshake engine.

	// Commands are always taken; data only by a listener that is not talking, so a talker never hears itself.
	assign hs.acc_en = b.atn | (st_q.listen & ~st_q.talk);
	assign hs.can_take = b.atn | ~st_q.rx_full;
	assign hs.src_en = st_q.talk & ~b.atn;
	assign hs.tx_req = st_q.spoll | st_q.tx_req;

	gim_hs u_hs (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.i_bus(b),
		.hsp(hs.eng),
		.o_dav_n(O_DAV_N),
		.o_dav_oe_n(O_DAV_OE_N),
		.o_nrfd_oe_n(O_NRFD_OE_N),
		.o_ndac_oe_n(O_NDAC_OE_N)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interface state.

	assign cmd = hs.rx_byte[6:0];
	assign req = I_AVS_READ | I_AVS_WRITE;
	assign acc = req & ~st_q.wreq;
	assign wd = I_AVS_WRITEDATA;
	assign ppoll = b.atn & b.eoi;
	assign src_act = st_q.talk & ~b.atn;
	assign src_data = st_q.spoll ? stb_byte(st_q) : st_q.tx_byte;

	// Software clears come first so that a hardware event in the same cycle wins.
	always_comb begin
		st_d = st_q;
		st_d.dcl_p = 1'b0;
		st_d.trg_p = 1'b0;
		st_d.wreq = ~(req & st_q.wreq);
		if (req & st_q.wreq) begin
			st_d.rdata = rd_word(st_q, I_AVS_ADDRESS);
		end
		if (acc & I_AVS_WRITE) begin
			if (I_AVS_ADDRESS == gim_pkg::REG_CTRL) begin
				st_d.addr = wd[gim_pkg::CTRL_ADDR_LSB +: 5];
				st_d.cr_only = wd[gim_pkg::CTRL_CRONLY_BIT];
				st_d.stb = wd[gim_pkg::CTRL_STB_LSB +: 8];
			end else if (I_AVS_ADDRESS == gim_pkg::REG_STAT) begin
				st_d.msg_done = st_q.msg_done & ~wd[gim_pkg::ST_MSGDONE];
				st_d.dcl = st_q.dcl & ~wd[gim_pkg::ST_DCL];
				st_d.trg = st_q.trg & ~wd[gim_pkg::ST_TRG];
				st_d.rsv = st_q.rsv | wd[gim_pkg::ST_RSV];
			end else if (I_AVS_ADDRESS == gim_pkg::REG_TXD && !st_q.tx_req) begin
				st_d.tx_req = 1'b1;
				st_d.tx_stb = wd[gim_pkg::DW_STB_BIT];
				st_d.tx_last = wd[gim_pkg::DW_LAST_BIT] | wd[gim_pkg::DW_STB_BIT];
				st_d.tx_byte = wd[gim_pkg::DW_STB_BIT] ? stb_byte(st_q) : wd[7:0];
			end
		end
		if (acc & I_AVS_READ & (I_AVS_ADDRESS == gim_pkg::REG_RXD)) begin
			st_d.rx_full = 1'b0;
		end
		// Front-panel local key works only without lockout.
		if (!b.ren) begin
			st_d.remote = 1'b0;
			st_d.lockout = 1'b0;
		end else if (I_PANEL_LOCAL && !st_q.lockout) begin
			st_d.remote = 1'b0;
		end
		// Commands are decoded by every device, addressed or not.
		if (hs.rx_stb && hs.rx_atn) begin
			st_d.pp_cfg = 1'b0;
			unique case (cmd[6:5])
				gim_pkg::GRP_LAG: begin
					if (cmd[4:0] == st_q.addr) begin
						st_d.listen = 1'b1;
						st_d.remote = st_d.remote | b.ren;
					end else if (cmd[4:0] == gim_pkg::ADDR_NONE) begin
						st_d.listen = 1'b0;
					end
				end
				gim_pkg::GRP_TAG: begin
					st_d.talk = (cmd[4:0] == st_q.addr);
				end
				gim_pkg::GRP_SCG: begin
					if (st_q.pp_cfg) begin
						st_d.pp_cfg = 1'b1;
						st_d.pp_en = ~cmd[4];
						st_d.pp_sense = cmd[3];
						st_d.pp_line = cmd[2:0];
					end
				end
				default: begin
					if (cmd == gim_pkg::CMD_LLO) begin
						st_d.lockout = 1'b1;
					end
					if (cmd == gim_pkg::CMD_DCL || (cmd == gim_pkg::CMD_SDC && st_q.listen)) begin
						st_d.dcl = 1'b1;
						st_d.dcl_p = 1'b1;
					end
					if (cmd == gim_pkg::CMD_GET && st_q.listen) begin
						st_d.trg = 1'b1;
						st_d.trg_p = 1'b1;
					end
					if (cmd == gim_pkg::CMD_GTL && st_q.listen) begin
						st_d.remote = 1'b0;
					end
					st_d.pp_cfg = (cmd == gim_pkg::CMD_PPC) && st_q.listen;
					if (cmd == gim_pkg::CMD_PPU) begin
						st_d.pp_en = 1'b0;
					end
					if (cmd == gim_pkg::CMD_SPE || cmd == gim_pkg::CMD_SPD) begin
						st_d.spoll = (cmd == gim_pkg::CMD_SPE);
					end
				end
			endcase
		end
		// Data bytes go to the decoder word; a terminator or end-or-identify ends a message.
		if (hs.rx_stb && !hs.rx_atn) begin
			st_d.rx_byte = hs.rx_byte;
			st_d.rx_eoi = hs.rx_eoi;
			st_d.rx_full = 1'b1;
			st_d.cr_seen = (hs.rx_byte == gim_pkg::CHR_CR);
			if (hs.rx_eoi || (st_q.cr_only ? hs.rx_byte == gim_pkg::CHR_CR
				: (st_q.cr_seen && hs.rx_byte == gim_pkg::CHR_LF))) begin
				st_d.msg_done = 1'b1;
			end
		end
		// A status byte that leaves the device ends the service request.
		if (hs.tx_done) begin
			if (st_q.spoll || st_q.tx_stb) begin
				st_d.rsv = 1'b0;
			end
			if (!st_q.spoll) begin
				st_d.tx_req = 1'b0;
			end
		end
		if (b.ifc) begin
			st_d.talk = 1'b0;
			st_d.listen = 1'b0;
			st_d.spoll = 1'b0;
			st_d.rsv = 1'b0;
		end
		// Pins: the talker drives all eight lines, a poll answer drives only its own.
		st_d.dio_n = ~src_data;
		st_d.dio_oe_n = 8'hFF;
		if (src_act) begin
			st_d.dio_oe_n = 8'h00;
		end else if (ppoll && st_q.pp_en && (st_q.rsv == st_q.pp_sense)) begin
			st_d.dio_n = 8'h00;
			st_d.dio_oe_n[st_q.pp_line] = 1'b0;
		end
		st_d.eoi_oe_n = ~src_act;
		st_d.eoi_n = ~(src_act & ~st_q.spoll & st_q.tx_req & st_q.tx_last);
		st_d.srq_oe_n = ~st_d.rsv;
	end

	// Synchronous reset to the power-up settings.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			st_q <= TOP_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign O_AVS_READDATA = st_q.rdata;
	assign O_AVS_WAITREQUEST = st_q.wreq;
	assign O_DIO_N = st_q.dio_n;
	assign O_DIO_OE_N = st_q.dio_oe_n;
	assign O_EOI_N = st_q.eoi_n;
	assign O_EOI_OE_N = st_q.eoi_oe_n;
	assign O_SRQ_OE_N = st_q.srq_oe_n;
	assign O_REMOTE = st_q.remote;
	assign O_DEV_CLEAR = st_q.dcl_p;
	assign O_TRIGGER = st_q.trg_p;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RESET);

	a_ifc_quiet: assert property (b.ifc |=> !st_q.talk && !st_q.listen && !st_q.spoll && O_SRQ_OE_N)
		else $error("Interface clear left the device addressed.");
	a_ren_local: assert property (!b.ren |=> !O_REMOTE)
		else $error("Remote kept without remote enable.");
	a_remote_cause: assert property ($rose(st_q.remote) |-> $past(b.ren && hs.rx_stb && hs.rx_atn))
		else $error("Remote entered without addressing.");
	a_cmd_not_data: assert property (hs.rx_stb && hs.rx_atn |=> $stable(st_q.rx_byte))
		else $error("Command byte reached the data word.");
	a_data_listen: assert property (hs.rx_stb && !hs.rx_atn && !b.ifc |-> st_q.listen ##1 st_q.rx_full)
		else $error("Data byte taken while not a listener.");
	a_eoi_last: assert property ($fell(O_DAV_N) && !st_q.spoll |-> O_EOI_N == !st_q.tx_last)
		else $error("End-or-identify does not match the last byte.");
	a_pp_answer: assert property (ppoll && st_q.pp_en && st_q.rsv == st_q.pp_sense && !b.ifc
		|=> !O_DIO_OE_N[st_q.pp_line] && !O_DIO_N[st_q.pp_line])
		else $error("Parallel poll not answered.");
	a_dio_drive: assert property (O_DIO_OE_N != 8'hFF |-> $past(src_act || ppoll))
		else $error("Data lines driven without cause.");
	a_spoll_rsv: assert property (hs.tx_done && st_q.spoll |=> !st_q.rsv && O_SRQ_OE_N)
		else $error("Service request kept after serial poll.");
	a_srq_line: assert property ($rose(st_q.rsv) |-> !O_SRQ_OE_N ##1 !O_SRQ_OE_N || !st_q.rsv)
		else $error("Service request line not asserted.");
	a_term_crlf: assert property (hs.rx_stb && !hs.rx_atn && !st_q.cr_only && st_q.cr_seen
		&& hs.rx_byte == gim_pkg::CHR_LF |=> st_q.msg_done)
		else $error("CR LF did not end the message.");

	c_spoll_byte: cover property (st_q.spoll && hs.tx_done);
	c_ppoll_resp: cover property (ppoll && O_DIO_OE_N != 8'hFF);
	c_msg_end: cover property ($rose(st_q.msg_done));

endmodule // gim_top

// file: verification/gim_ctl_model.sv
module gim_ctl_model (
	// Clock.
	input wire logic i_clk,
	// Device drives and enables.
	input wire logic [7:0] i_dio_n,
	input wire logic [7:0] i_dio_oe_n,
	input wire logic i_dav_n,
	input wire logic i_dav_oe_n,
	input wire logic i_eoi_n,
	input wire logic i_eoi_oe_n,
	input wire logic i_nrfd_oe_n,
	input wire logic i_ndac_oe_n,
	// Resolved wire levels, low is true.
	output logic o_atn_n,
	output logic o_ifc_n,
	output logic o_ren_n,
	output logic o_eoi_n,
	output logic o_dav_n,
	output logic o_nrfd_n,
	output logic o_ndac_n,
	output logic [7:0] o_dio_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] c_dio = 8'hFF;
	logic c_dav = 1'h1;
	logic c_eoi = 1'h1;
	logic c_nrfd = 1'h1;
	logic c_ndac = 1'h1;
	int n_to = 0;

	// Only this model drives clear and remote enable; the device has no pins for them.
	initial begin
		o_atn_n = 1'h1;
		o_ifc_n = 1'h1;
		o_ren_n = 1'h1;
	end

	// Wired lines: released lines float high on the terminators.
	assign o_dio_n = c_dio & (i_dio_n | i_dio_oe_n);
	assign o_dav_n = c_dav & (i_dav_n | i_dav_oe_n);
	assign o_eoi_n = c_eoi & (i_eoi_n | i_eoi_oe_n);
	assign o_nrfd_n = c_nrfd & i_nrfd_oe_n;
	assign o_ndac_n = c_ndac & i_ndac_oe_n;

	////////////////////////////////////////////////////////////////
	// Source one byte; commands go with attention true.
	task automatic send(input logic [7:0] b, input logic atn, input logic last);
		int i;
		@(posedge i_clk);
		o_atn_n <= !atn;
		c_dio <= ~b;
		c_eoi <= !last;
		// Long settle so a talker dropping off on attention has let go.
		repeat (4) @(posedge i_clk);
		for (i = 0; i < 200 && o_nrfd_n !== 1'h1; i++) @(posedge i_clk);
		if (i == 200) n_to++;
		c_dav <= 1'h0;
		@(posedge i_clk);
		for (i = 0; i < 200 && o_ndac_n !== 1'h1; i++) @(posedge i_clk);
		if (i == 200) n_to++;
		c_dav <= 1'h1;
		c_eoi <= 1'h1;
		c_dio <= 8'hFF;
		repeat (3) @(posedge i_clk);
	endtask

	// Accept one byte from the device as sole listener.
	task automatic recv(output logic [7:0] b, output logic e);
		int i;
		@(posedge i_clk);
		o_atn_n <= 1'h1;
		c_ndac <= 1'h0;
		for (i = 0; i < 200 && o_dav_n !== 1'h0; i++) @(posedge i_clk);
		if (i == 200) n_to++;
		b = ~o_dio_n;
		e = !o_eoi_n;
		c_nrfd <= 1'h0;
		@(posedge i_clk);
		c_ndac <= 1'h1;
		for (i = 0; i < 200 && o_dav_n !== 1'h1; i++) @(posedge i_clk);
		if (i == 200) n_to++;
		c_nrfd <= 1'h1;
	endtask

	// Set the uniline messages, hold them n cycles, sample the data lines.
	task automatic mgmt(input logic atn, eoi, ifc, ren, input int n, output logic [7:0] b);
		@(posedge i_clk);
		o_atn_n <= !atn;
		c_eoi <= !eoi;
		o_ifc_n <= !ifc;
		o_ren_n <= !ren;
		repeat (n) @(posedge i_clk);
		b = ~o_dio_n;
	endtask
endmodule // gim_ctl_model

// file: verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic I_CLK = 1'h0;
	logic I_RESET = 1'h1;
	logic [1:0] I_AVS_ADDRESS = 2'h0;
	logic I_AVS_READ = 1'h0;
	logic I_AVS_WRITE = 1'h0;
	logic [31:0] I_AVS_WRITEDATA = 32'h0;
	logic I_PANEL_LOCAL = 1'h0;
	logic [31:0] O_AVS_READDATA;
	logic O_AVS_WAITREQUEST;
	logic I_ATN_N, I_EOI_N, I_IFC_N, I_REN_N, I_DAV_N, I_NRFD_N, I_NDAC_N;
	logic [7:0] I_DIO_N, O_DIO_N, O_DIO_OE_N;
	logic O_DAV_N, O_DAV_OE_N, O_EOI_N, O_EOI_OE_N, O_NRFD_OE_N, O_NDAC_OE_N, O_SRQ_OE_N;
	logic O_REMOTE, O_DEV_CLEAR, O_TRIGGER;
	logic [7:0] b;
	logic e;
	logic [7:0] msg [3] = '{8'h41, 8'h0D, 8'h0A};
	int n_errors = 0;
	int checks_done = 0;
	int n_clr = 0;
	int n_trg = 0;

	gim_top dut (.I_CLK, .I_RESET, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA,
		.O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_ATN_N, .I_EOI_N, .I_IFC_N, .I_REN_N, .I_DAV_N,
		.I_NRFD_N, .I_NDAC_N, .I_DIO_N, .O_DIO_N, .O_DIO_OE_N, .O_DAV_N, .O_DAV_OE_N, .O_EOI_N,
		.O_EOI_OE_N, .O_NRFD_OE_N, .O_NDAC_OE_N, .O_SRQ_OE_N, .I_PANEL_LOCAL, .O_REMOTE,
		.O_DEV_CLEAR, .O_TRIGGER);

	gim_ctl_model u_ctl (.i_clk(I_CLK), .i_dio_n(O_DIO_N), .i_dio_oe_n(O_DIO_OE_N),
		.i_dav_n(O_DAV_N), .i_dav_oe_n(O_DAV_OE_N), .i_eoi_n(O_EOI_N), .i_eoi_oe_n(O_EOI_OE_N),
		.i_nrfd_oe_n(O_NRFD_OE_N), .i_ndac_oe_n(O_NDAC_OE_N), .o_atn_n(I_ATN_N),
		.o_ifc_n(I_IFC_N), .o_ren_n(I_REN_N), .o_eoi_n(I_EOI_N), .o_dav_n(I_DAV_N),
		.o_nrfd_n(I_NRFD_N), .o_ndac_n(I_NDAC_N), .o_dio_n(I_DIO_N));

	// 40 MHz clock.
	initial begin
		forever #12.5 I_CLK = ~I_CLK;
	end

	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("Checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge I_CLK);
		I_AVS_ADDRESS <= a;
		I_AVS_WRITE <= w;
		I_AVS_READ <= !w;
		I_AVS_WRITEDATA <= d;
		i = 0;
		do begin
			@(posedge I_CLK);
			i++;
		end while (O_AVS_WAITREQUEST !== 1'h0 && i < 50);
		if (O_AVS_WAITREQUEST !== 1'h0) begin
			n_errors++;
			finish_test();
		end else begin
			q = O_AVS_READDATA;
			I_AVS_READ <= 1'h0;
			I_AVS_WRITE <= 1'h0;
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'h1, d, q);
	endtask

	// Masked register read against an expected value.
	task automatic rg(input logic [1:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
		logic [31:0] q;
		bus(a, 1'h0, 32'h0, q);
		chk(nm, q & m, x);
	endtask

	// A handshake that stalls ends the run.
	always @(posedge I_CLK) begin
		if (u_ctl.n_to != 0) begin
			n_errors++;
			finish_test();
		end
	end

	// Clear and trigger stand for one cycle only, so every edge is counted.
	always @(posedge I_CLK) begin
		if (O_DEV_CLEAR === 1'h1) begin
			n_clr++;
		end
		if (O_TRIGGER === 1'h1) begin
			n_trg++;
		end
	end

	initial begin
		repeat (20000) @(posedge I_CLK);
		n_errors++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////
	// Main sequence; the bus commands are seven-bit codes with bit 7 clear.
	initial begin
		repeat (4) @(posedge I_CLK);
		I_RESET <= 1'h0;
		repeat (3) @(posedge I_CLK);
		rg(gim_pkg::REG_CTRL, 32'h3F, 32'h05, "ctrl_reset");
		chk("dio_released", O_DIO_OE_N, 32'hFF);
		rg(gim_pkg::REG_TXD, 32'hFFFFFFFF, 32'h0, "txd_read");
		// Data before any addressing must be left alone.
		u_ctl.send(8'h41, 1'h0, 1'h0);
		rg(gim_pkg::REG_STAT, 32'h26, 32'h0, "rx_unaddressed");
		// Remote enable, then my listen address.
		u_ctl.mgmt(1'h0, 1'h0, 1'h0, 1'h1, 4, b);
		u_ctl.send(8'h25, 1'h1, 1'h0);
		rg(gim_pkg::REG_STAT, 32'h07, 32'h03, "listen_remote");
		chk("remote_on", O_REMOTE, 32'h1);
		for (int i = 0; i < 3; i++) begin
			u_ctl.send(msg[i], 1'h0, 1'h0);
			rg(gim_pkg::REG_RXD, 32'h3FF, 32'h200 | msg[i], "rx_byte");
			rg(gim_pkg::REG_STAT, 32'h80, (i == 2) ? 32'h80 : 32'h0, "done_crlf");
		end
		wr(gim_pkg::REG_STAT, 32'h80);
		wr(gim_pkg::REG_CTRL, 32'h25);
		u_ctl.send(8'h0D, 1'h0, 1'h0);
		rg(gim_pkg::REG_RXD, 32'h3FF, 32'h20D, "rx_cr");
		rg(gim_pkg::REG_STAT, 32'h80, 32'h80, "done_cr");
		u_ctl.send(8'h5A, 1'h0, 1'h1);
		rg(gim_pkg::REG_RXD, 32'h3FF, 32'h35A, "rx_eoi");
		// Lockout: the panel key must not return to local.
		u_ctl.send(8'h11, 1'h1, 1'h0);
		I_PANEL_LOCAL <= 1'h1;
		repeat (6) @(posedge I_CLK);
		chk("remote_locked", O_REMOTE, 32'h1);
		I_PANEL_LOCAL <= 1'h0;
		// Talk address, then two bytes with end on the last.
		u_ctl.send(8'h45, 1'h1, 1'h0);
		rg(gim_pkg::REG_STAT, 32'h04, 32'h04, "talker");
		wr(gim_pkg::REG_TXD, 32'h58);
		u_ctl.recv(b, e);
		chk("tx_first", {b, 7'h0, e}, 32'h5800);
		wr(gim_pkg::REG_TXD, 32'h159);
		u_ctl.recv(b, e);
		chk("tx_last", {b, 7'h0, e}, 32'h5901);
		// Service request and serial poll.
		wr(gim_pkg::REG_CTRL, 32'h0105);
		wr(gim_pkg::REG_STAT, 32'h10);
		repeat (2) @(posedge I_CLK);
		chk("srq_on", O_SRQ_OE_N, 32'h0);
		u_ctl.send(8'h18, 1'h1, 1'h0);
		u_ctl.send(8'h45, 1'h1, 1'h0);
		u_ctl.recv(b, e);
		chk("spoll_byte", b, 32'h41);
		u_ctl.send(8'h19, 1'h1, 1'h0);
		chk("srq_off", O_SRQ_OE_N, 32'h1);
		// Parallel poll on line 2 with sense one.
		u_ctl.send(8'h25, 1'h1, 1'h0);
		u_ctl.send(8'h05, 1'h1, 1'h0);
		u_ctl.send(8'h6A, 1'h1, 1'h0);
		wr(gim_pkg::REG_STAT, 32'h10);
		u_ctl.mgmt(1'h1, 1'h1, 1'h0, 1'h1, 6, b);
		chk("ppoll", b, 32'h04);
		u_ctl.mgmt(1'h1, 1'h0, 1'h0, 1'h1, 2, b);
		// Trigger and device clear while listener.
		u_ctl.send(8'h08, 1'h1, 1'h0);
		u_ctl.send(8'h14, 1'h1, 1'h0);
		rg(gim_pkg::REG_STAT, 32'hE00, 32'hE00, "trig_clear");
		chk("clear_pulse", n_clr, 32'h1);
		chk("trig_pulse", n_trg, 32'h1);
		// Unconfigure drops the poll answer; go-to-local holds until readdressed.
		u_ctl.send(8'h15, 1'h1, 1'h0);
		rg(gim_pkg::REG_STAT, 32'h800, 32'h0, "pp_off");
		u_ctl.send(8'h01, 1'h1, 1'h0);
		chk("gtl_local", O_REMOTE, 32'h0);
		u_ctl.send(8'h25, 1'h1, 1'h0);
		chk("remote_again", O_REMOTE, 32'h1);
		// Interface clear while a service request is pending.
		wr(gim_pkg::REG_STAT, 32'h10);
		u_ctl.mgmt(1'h1, 1'h0, 1'h1, 1'h1, 6, b);
		rg(gim_pkg::REG_STAT, 32'h16, 32'h0, "ifc_idle");
		chk("ifc_srq", O_SRQ_OE_N, 32'h1);
		u_ctl.mgmt(1'h0, 1'h0, 1'h0, 1'h1, 2, b);
		u_ctl.mgmt(1'h0, 1'h0, 1'h0, 1'h0, 6, b);
		chk("remote_off", O_REMOTE, 32'h0);
		finish_test();
	end
endmodule // tb
